/* File: bench/tb.sv */
`timescale 1ns/1ps
module tb;
	import tsr_pkg::*;
	localparam logic [2:0] STRAP  = 3'h5;
	localparam logic [7:0] NV_CTL = 8'hDB;
	logic        clk, reset, scl, host_oe, store_req, conv_done, conv_hold, conv_busy;
	logic        sda_oe, sda_out, nv_store, conv_start, fault_clr, lvl, behav, pdown;
	logic [1:0]  prec, fault;
	logic [7:0]  nv_data, conv_cnt;
	logic [11:0] temp_bits;
	logic [6:0]  fields;
	wire logic   sda;
	int          err_count, n_checks, n_starts;
	// Pulled-up line, low when either side pulls
	assign sda = !(host_oe || (sda_oe && !sda_out));
	assign fields = {prec, fault, lvl, behav, pdown};
	tsr_temp_sensor uut (
		.i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
		.i_strapped_address_bits(STRAP), .i_nv_control(NV_CTL), .i_store_request(store_req),
		.o_nv_store(nv_store), .o_nv_control_data(nv_data), .o_conv_start(conv_start),
		.i_conv_done(conv_done), .i_temperature_bits(temp_bits), .o_conversion_precision(prec),
		.o_fault_queue_depth(fault), .o_alarm_active_level(lvl), .o_alarm_behaviour_select(behav),
		.o_power_down_select(pdown), .o_fault_count_clear(fault_clr)
	);
	tsr_host_model host (.o_scl(scl), .o_sda_oe(host_oe), .i_sda(sda));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = !clk;
	end
	// Converter: done 201 cycles after a start, stalls while held
	always @(posedge clk) begin
		conv_done <= 1'b0;
		if (conv_start) begin
			conv_busy <= 1'b1;
			conv_cnt <= 8'h00;
			n_starts <= n_starts + 1;
		end else if (conv_busy && !conv_hold) begin
			conv_cnt <= conv_cnt + 8'h01;
			if (conv_cnt == 8'hC8) begin
				conv_done <= 1'b1;
				conv_busy <= 1'b0;
			end
		end
	end
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic wait_done();
		int i;
		for (i = 0; i < 4000 && conv_done !== 1'b1; i++) @(posedge clk);
		if (conv_done !== 1'b1) begin
			check("conversion done", 24'h0, 24'h1);
			tally_and_finish();
		end
		repeat (3) @(posedge clk);
	endtask : wait_done
	// Read n bytes, then one more byte to see the line released
	task automatic rd(input int n, output logic [23:0] w);
		logic [7:0] b;
		logic a;
		w = '0;
		host.start();
		host.xfer({TSR_ADDR_FIXED, STRAP, 1'b1}, 1'b1, b, a);
		check("read address ack", 24'(a), 24'h0);
		for (int i = 1; i <= n; i++) begin
			host.xfer(8'hFF, i == n, b, a);
			w = {w[15:0], b};
		end
		host.xfer(8'hFF, 1'b1, b, a);
		check("released line", 24'(b), 24'hFF);
		host.stop();
	endtask : rd
	task automatic wr(input logic [7:0] ptr, input logic with_data, input logic [7:0] d, output logic [1:0] acks);
		logic [7:0] q;
		logic a;
		host.start();
		host.xfer({TSR_ADDR_FIXED, STRAP, 1'b0}, 1'b1, q, a);
		check("write address ack", 24'(a), 24'h0);
		host.xfer(ptr, 1'b1, q, acks[1]);
		acks[0] = 1'b0;
		if (with_data) host.xfer(d, 1'b1, q, acks[0]);
		host.stop();
	endtask : wr
	task automatic t_boot();
		logic [23:0] w;
		check("fields after reset", 24'(fields), 24'(NV_CTL[6:0]));
		check("boot starts", 24'(n_starts), 24'h1);
		rd(2, w);
		check("result after reset", w, 24'h0);
		@(posedge clk) store_req <= 1'b1;
		@(posedge clk) store_req <= 1'b0;
		@(posedge clk);
		check("store", {15'h0, nv_store, nv_data}, {16'h1, 1'b0, NV_CTL[6:0]});
		temp_bits <= 12'hF5F;
		conv_hold <= 1'b0;
		wait_done();
		rd(2, w);
		check("boot result", w, 24'hF5E0);
		check("starts in shutdown", 24'(n_starts), 24'h1);
	endtask : t_boot
	task automatic t_single();
		logic [1:0] acks;
		logic [23:0] w;
		wr(TSR_PTR_CONTROL, 1'b1, 8'hE1, acks);
		check("control write acks", 24'(acks), 24'h0);
		wait_done();
		check("single shot starts", 24'(n_starts), 24'h2);
		check("fields", 24'(fields), 24'h61);
		rd(2, w);
		check("control read", w, 24'h6100);
	endtask : t_single
	task automatic t_prec();
		logic [1:0] acks;
		logic [23:0] w;
		logic [7:0] c;
		@(posedge clk) temp_bits <= 12'hFFF;
		for (int p = 0; p < 4; p++) begin
			c = {1'b0, 2'(p), 2'(p), p[0], p[1], 1'b0};
			wr(TSR_PTR_CONTROL, 1'b1, c, acks);
			check("fields", 24'(fields), 24'(c[6:0]));
			wait_done();
			wait_done();
			wr(TSR_PTR_TEMPERATURE, 1'b0, 8'h00, acks);
			rd(2, w);
			check("masked result", w, 24'(16'(TSR_MASK_FINEST << (3 - p))));
		end
	endtask : t_prec
	task automatic t_reads();
		logic [23:0] w;
		@(posedge clk) temp_bits <= 12'h194;
		wait_done();
		rd(1, w);
		check("upper byte only", w, 24'h19);
		rd(3, w);
		check("word then upper", w, 24'h19_4019);
	endtask : t_reads
	// Conversion ends in mid-read; the old word goes out first
	task automatic t_hold();
		logic [23:0] w;
		@(posedge clk) conv_hold <= 1'b1;
		repeat (250) @(posedge clk);
		temp_bits <= 12'h7D0;
		fork
			rd(2, w);
			begin
				repeat (300) @(posedge clk);
				conv_hold <= 1'b0;
			end
		join
		conv_hold <= 1'b1;
		check("read during conversion", w, 24'h1940);
		rd(2, w);
		check("pending result", w, 24'h7D00);
		conv_hold <= 1'b0;
	endtask : t_hold
	task automatic t_refuse();
		logic [1:0] acks;
		logic [7:0] q;
		logic a;
		wr(TSR_PTR_TEMPERATURE, 1'b1, 8'h55, acks);
		check("result write acks", 24'(acks), 24'h1);
		wr(8'h05, 1'b0, 8'h00, acks);
		check("bad pointer ack", 24'(acks), 24'h2);
		host.start();
		host.xfer({TSR_ADDR_FIXED, ~STRAP, 1'b1}, 1'b1, q, a);
		host.stop();
		check("foreign address ack", 24'(a), 24'h1);
	endtask : t_refuse
	initial begin
		reset = 1'b1;
		store_req = 1'b0;
		conv_hold = 1'b1;
		conv_busy = 1'b0;
		temp_bits = 12'h000;
		err_count = 0;
		n_checks = 0;
		n_starts = 0;
		fork
			host.pulses(4);
			repeat (80) @(posedge clk);
		join
		@(posedge clk) reset <= 1'b0;
		// Link side leaves reset only on serial clock edges
		host.pulses(3);
		repeat (5) @(posedge clk);
		t_boot();
		t_single();
		t_prec();
		t_reads();
		t_hold();
		t_refuse();
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge clk);
		check("run time", 24'h0, 24'h1);
		tally_and_finish();
	end
endmodule : tb

/* File: bench/tsr_checker_properties.sv */
`timescale 1ns/1ps
module tsr_checker (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_scl,
	input wire logic [7:0] i_nv_control,
	input wire logic       i_store_request,
	input wire logic       i_conv_done,
	input wire logic       o_sda_oe,
	input wire logic       o_nv_store,
	input wire logic [7:0] o_nv_control_data,
	input wire logic       o_conv_start,
	input wire logic [1:0] o_conversion_precision,
	input wire logic [1:0] o_fault_queue_depth,
	input wire logic       o_alarm_active_level,
	input wire logic       o_alarm_behaviour_select,
	input wire logic       o_power_down_select,
	input wire logic       o_fault_count_clear
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Working control byte as shown on the field outputs
	logic [6:0] fields;
	assign fields = {o_conversion_precision, o_fault_queue_depth, o_alarm_active_level,
		o_alarm_behaviour_select, o_power_down_select};
	sequence store_seq;
		i_store_request ##1 o_nv_store;
	endsequence
	boot_start_a: assert property ($fell(i_reset) |=> o_conv_start)
		else $error("no conversion after reset");
	restart_conv_a: assert property (i_conv_done && !o_power_down_select |=> ##1 o_conv_start)
		else $error("continuous conversion did not restart");
	start_pulse_a: assert property (o_conv_start |=> !o_conv_start)
		else $error("conversion start longer than one cycle");
	store_pulse_a: assert property (i_store_request |-> store_seq)
		else $error("store request not passed on");
	store_data_a: assert property (o_nv_store |-> o_nv_control_data == {1'b0, fields})
		else $error("stored byte differs from working byte");
	reset_copy_a: assert property ($fell(i_reset) |-> {1'b0, fields} == ($past(i_nv_control) & 8'h7F))
		else $error("control not copied from stored byte");
	oe_on_low_a: assert property ($rose(o_sda_oe) |-> !i_scl)
		else $error("data line taken while serial clock high");
	fields_clear_a: assert property ($changed(fields) |-> o_fault_count_clear)
		else $error("control update without fault count clear");
endmodule : tsr_checker
bind tsr_temp_sensor tsr_checker u_chk (.*);

/* File: bench/tsr_host_model.sv */
`timescale 1ns/1ps
// Bus controller; clock idles high, released line reads high
module tsr_host_model (
	output logic      o_scl,
	output logic      o_sda_oe,
	input  wire logic i_sda
);
	localparam realtime QTR = 31.25;
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// Free clock pulses so the link side sees reset
	task automatic pulses(input int n);
		repeat (n) begin
			#(2 * QTR) o_scl = 1'b0;
			#(2 * QTR) o_scl = 1'b1;
		end
	endtask : pulses
	// Start or repeated start: line falls while clock high
	task automatic start();
		o_sda_oe = 1'b0;
		#QTR o_scl = 1'b1;
		#QTR o_sda_oe = 1'b1;
		#QTR o_scl = 1'b0;
		#QTR;
	endtask : start
	task automatic stop();
		o_sda_oe = 1'b1;
		#QTR o_scl = 1'b1;
		#QTR o_sda_oe = 1'b0;
		#QTR;
	endtask : stop
	// Eight bits and the acknowledge slot; a one releases the line
	task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack_seen);
		logic [8:0] v;
		logic [8:0] r;
		v = {d, ack_bit};
		for (int i = 8; i >= 0; i--) begin
			o_sda_oe = !v[i];
			#QTR o_scl = 1'b1;
			#QTR r[i] = i_sda;
			#QTR o_scl = 1'b0;
			#QTR;
		end
		// Line keeps the acknowledge level until the next bit is set up
		q = r[8:1];
		ack_seen = r[0];
	endtask : xfer
endmodule : tsr_host_model

/* File: verilog/tsr_link_sampler.sv */
`timescale 1ns/1ps
module tsr_link_sampler (
	input  wire logic i_scl,
	input  wire logic i_reset,
	input  wire logic i_sda,
	output logic      o_bit,
	output logic      o_toggle
);
	import tsr_pkg::*;

	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic bit_value;
		logic toggle;
	} tsr_link_state_type;

	tsr_link_state_type cur;
	tsr_link_state_type next_cur;

	// Sample data on each serial clock rise, flag it by a toggle
	always_comb begin
		next_cur        = cur;
		next_cur.rst_s1 = i_reset;
		next_cur.rst_s2 = cur.rst_s1;
		if (cur.rst_s2) begin
			next_cur.bit_value = 1'b0;
			next_cur.toggle    = 1'b0;
		end else begin
			next_cur.bit_value = i_sda;
			next_cur.toggle    = ~cur.toggle;
		end
	end

	// Link side state register
	always_ff @(posedge i_scl) begin
		cur <= next_cur;
	end

	assign o_bit    = cur.bit_value;
	assign o_toggle = cur.toggle;

endmodule : tsr_link_sampler

/* File: verilog/tsr_pkg.sv */
package tsr_pkg;

	// Register selection values held in the pointer
	localparam logic [7:0]  TSR_PTR_TEMPERATURE = 8'h00;
	localparam logic [7:0]  TSR_PTR_CONTROL     = 8'h01;
	localparam logic [7:0]  TSR_PTR_RESET       = 8'h00;

	// Values after reset
	localparam logic [15:0] TSR_TEMP_RESET      = 16'h0000;
	localparam logic [7:0]  TSR_CTRL_LOW_BYTE   = 8'h00;
	localparam logic [7:0]  TSR_SHIFT_RESET     = 8'h00;
	localparam logic [15:0] TSR_WORD_RESET      = 16'h0000;

	// Fixed upper bits of the bus address
	localparam logic [3:0]  TSR_ADDR_FIXED      = 4'h9;

	// Field positions inside the upper control byte
	localparam int          TSR_CTL_SINGLE_SHOT = 7;
	localparam int          TSR_CTL_PREC_HI     = 6;
	localparam int          TSR_CTL_PREC_LO     = 5;
	localparam int          TSR_CTL_FAULT_HI    = 4;
	localparam int          TSR_CTL_FAULT_LO    = 3;
	localparam int          TSR_CTL_ALARM_LEVEL = 2;
	localparam int          TSR_CTL_ALARM_BEHAV = 1;
	localparam int          TSR_CTL_POWER_DOWN  = 0;

	// Result mask at the finest precision, shifted per coarser step
	localparam logic [15:0] TSR_MASK_FINEST     = 16'hFFF0;
	localparam logic [1:0]  TSR_PREC_FINEST     = 2'h3;

	// Bit count that marks the acknowledge slot of a byte
	localparam logic [3:0]  TSR_BIT_ACK_SLOT    = 4'h8;
	localparam logic [3:0]  TSR_BIT_LAST_DATA   = 4'h7;

	// Bus transaction states, Gray ordered
	typedef enum logic [1:0] {
		TSR_IDLE  = 2'b00,
		TSR_ADDR  = 2'b01,
		TSR_WRITE = 2'b11,
		TSR_READ  = 2'b10
	} tsr_bus_state_type;

endpackage : tsr_pkg

/* File: verilog/tsr_temp_sensor.sv */
// Overview of operation
// - Result of the latest conversion sits in a 16-bit read-only register.
// - Reading the result never disturbs a running conversion.
// - Bit 15 is the sign; value coded in two's complement.
// - Result left-aligned, 9 to 12 bits by precision, lower bits zero.
// - A finished conversion loads when no read is in progress or on host ack after lower byte.
// - With pointer 00h, a read address 1001AAA1 is acknowledged.
// - Upper byte first, host ack, lower byte, host nack, line released.
// - Host ack after lower byte restarts with fresh data, upper byte first.
// - Host nack after upper byte withholds lower byte and releases line.
// - Result reads 0000h after reset; host waits a conversion time.
// - Starting in shutdown still performs one conversion after reset.
// - Data bytes written to the result register are not acknowledged.
// - Control register is 16 bits; only its upper byte holds settings.
// - Reset copies the stored upper control byte into the working copy.
// - Store command saves control byte to the nonvolatile copy.
// - Control bit 15 requests one conversion, honoured only in shutdown.
// - Control bits 12:11 choose 1, 2, 4 or 6 faults before alarm.
// - Control bit 10 sets alarm output level: 0 low, 1 high.
// - Control bit 9 selects comparator (0) or interrupt (1) alarm.
// - Control bit 8 selects shutdown; 0 converts continuously.
// - A single-shot conversion returns to shutdown and clears its request.
// - Pointer selects the result register after reset.
`timescale 1ns/1ps
module tsr_temp_sensor (
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe,
	input  wire logic [2:0]  i_strapped_address_bits,
	input  wire logic [7:0]  i_nv_control,
	input  wire logic        i_store_request,
	output logic             o_nv_store,
	output logic [7:0]       o_nv_control_data,
	output logic             o_conv_start,
	input  wire logic        i_conv_done,
	input  wire logic [11:0] i_temperature_bits,
	output logic [1:0]       o_conversion_precision,
	output logic [1:0]       o_fault_queue_depth,
	output logic             o_alarm_active_level,
	output logic             o_alarm_behaviour_select,
	output logic             o_power_down_select,
	output logic             o_fault_count_clear
);
	import tsr_pkg::*;

	typedef struct packed {
		logic              scl_s1;
		logic              scl_s2;
		logic              sda_s1;
		logic              sda_s2;
		logic              scl_prev;
		logic              sda_prev;
		logic [2:0]        strap_s1;
		logic [2:0]        strap_s2;
		logic              tog_s1;
		logic              tog_s2;
		logic              tog_seen;
		tsr_bus_state_type bus_state;
		logic [3:0]        bit_count;
		logic [7:0]        shift_in;
		logic [15:0]       out_word;
		logic              out_low;
		logic              ack_ok;
		logic              write_first;
		logic              write_data_seen;
		logic [7:0]        pointer;
		logic [15:0]       temperature;
		logic [15:0]       pending_value;
		logic              pending;
		logic [7:0]        control;
		logic              conv_busy;
		logic              boot_shot;
		logic              shot_active;
		logic              conv_start;
		logic              sda_oe;
		logic              fault_clear;
		logic              nv_store;
		logic [7:0]        nv_data;
	} tsr_core_state_type;

	tsr_core_state_type cur;
	tsr_core_state_type next_cur;
	logic               link_bit;
	logic               link_toggle;
	logic               start_seen;
	logic               stop_seen;
	logic               scl_fall;
	logic               bit_event;
	logic               reading;
	logic [7:0]         byte_in;
	logic [7:0]         out_byte;
	logic [15:0]        result_mask;
	logic [15:0]        fresh_result;

	// Serial clock domain bit sampler
	tsr_link_sampler u_link (
		.i_scl    (i_scl),
		.i_reset  (i_reset),
		.i_sda    (i_sda),
		.o_bit    (link_bit),
		.o_toggle (link_toggle)
	);

	// Bus conditions seen through the synchronised pins
	assign start_seen = cur.scl_s2 & cur.scl_prev & cur.sda_prev & ~cur.sda_s2;
	assign stop_seen  = cur.scl_s2 & cur.scl_prev & ~cur.sda_prev & cur.sda_s2;
	assign scl_fall   = cur.scl_prev & ~cur.scl_s2;
	assign bit_event  = cur.tog_s2 != cur.tog_seen;
	assign reading    = cur.bus_state == TSR_READ;
	assign byte_in    = {cur.shift_in[6:0], link_bit};
	assign out_byte   = cur.out_low ? cur.out_word[7:0] : cur.out_word[15:8];

	// Left-aligned result, unused low bits forced to zero
	assign result_mask  = TSR_MASK_FINEST << (TSR_PREC_FINEST
		- cur.control[TSR_CTL_PREC_HI:TSR_CTL_PREC_LO]);
	assign fresh_result = {i_temperature_bits, 4'h0} & result_mask;

	// Next state of the whole block
	always_comb begin
		next_cur             = cur;
		next_cur.scl_s1      = i_scl;
		next_cur.scl_s2      = cur.scl_s1;
		next_cur.sda_s1      = i_sda;
		next_cur.sda_s2      = cur.sda_s1;
		next_cur.scl_prev    = cur.scl_s2;
		next_cur.sda_prev    = cur.sda_s2;
		next_cur.strap_s1    = i_strapped_address_bits;
		next_cur.strap_s2    = cur.strap_s1;
		next_cur.tog_s1      = link_toggle;
		next_cur.tog_s2      = cur.tog_s1;
		next_cur.tog_seen    = cur.tog_s2;
		next_cur.conv_start  = 1'b0;
		next_cur.fault_clear = 1'b0;
		next_cur.nv_store    = 1'b0;

		// Held result loads once the read has ended
		if (!reading && cur.pending) begin
			next_cur.temperature = cur.pending_value;
			next_cur.pending     = 1'b0;
		end

		// Conversion finish: load or hold, runs beside any read
		if (i_conv_done && cur.conv_busy) begin
			next_cur.conv_busy = 1'b0;
			if (cur.shot_active) begin
				next_cur.control[TSR_CTL_SINGLE_SHOT] = 1'b0;
				next_cur.shot_active                  = 1'b0;
			end
			if (reading) begin
				next_cur.pending       = 1'b1;
				next_cur.pending_value = fresh_result;
			end else begin
				next_cur.temperature = fresh_result;
			end
		end else if (!cur.conv_busy) begin
			// Continuous, first after reset, or single shot
			if (!cur.control[TSR_CTL_POWER_DOWN] || cur.boot_shot
				|| cur.control[TSR_CTL_SINGLE_SHOT]) begin
				next_cur.conv_start  = 1'b1;
				next_cur.conv_busy   = 1'b1;
				next_cur.boot_shot   = 1'b0;
				next_cur.shot_active = cur.control[TSR_CTL_SINGLE_SHOT];
			end
		end

		// Save working control byte to the nonvolatile copy
		if (i_store_request) begin
			next_cur.nv_store = 1'b1;
			next_cur.nv_data  = cur.control & ~(8'h80);
		end

		// Serial transaction handling
		if (start_seen) begin
			next_cur.bus_state       = TSR_ADDR;
			next_cur.bit_count       = 4'h0;
			next_cur.sda_oe          = 1'b0;
			next_cur.write_first     = 1'b1;
			next_cur.write_data_seen = 1'b0;
			next_cur.out_low         = 1'b0;
		end else if (stop_seen) begin
			next_cur.bus_state = TSR_IDLE;
			next_cur.sda_oe    = 1'b0;
		end else begin
			if (bit_event && cur.bus_state != TSR_IDLE) begin
				if (cur.bit_count == TSR_BIT_ACK_SLOT) begin
					// Acknowledge slot has passed
					next_cur.bit_count = 4'h0;
					case (cur.bus_state)
						TSR_ADDR: begin
							if (!cur.ack_ok) begin
								next_cur.bus_state = TSR_IDLE;
							end else if (cur.shift_in[0]) begin
								next_cur.bus_state = TSR_READ;
								next_cur.out_low   = 1'b0;
								if (cur.pointer == TSR_PTR_CONTROL) begin
									next_cur.out_word = {cur.control & ~(8'h80), TSR_CTRL_LOW_BYTE};
								end else begin
									next_cur.out_word = cur.temperature;
								end
							end else begin
								next_cur.bus_state = TSR_WRITE;
							end
						end
						TSR_READ: begin
							if (link_bit) begin
								next_cur.bus_state = TSR_IDLE;
							end else if (!cur.out_low) begin
								next_cur.out_low = 1'b1;
							end else begin
								// Host wants more: fresh word, upper byte first
								next_cur.out_low = 1'b0;
								if (cur.pointer == TSR_PTR_CONTROL) begin
									next_cur.out_word = {next_cur.control & ~(8'h80), TSR_CTRL_LOW_BYTE};
								end else if (next_cur.pending) begin
									next_cur.temperature = next_cur.pending_value;
									next_cur.out_word    = next_cur.pending_value;
									next_cur.pending     = 1'b0;
								end else begin
									next_cur.out_word = next_cur.temperature;
								end
							end
						end
						default: begin
							next_cur.bus_state = cur.bus_state;
						end
					endcase
				end else begin
					next_cur.shift_in  = byte_in;
					next_cur.bit_count = cur.bit_count + 4'h1;
					if (cur.bit_count == TSR_BIT_LAST_DATA) begin
						// Whole byte in: decide the acknowledge
						case (cur.bus_state)
							TSR_ADDR: begin
								next_cur.ack_ok = byte_in[7:1] == {TSR_ADDR_FIXED, cur.strap_s2};
							end
							TSR_WRITE: begin
								if (cur.write_first) begin
									next_cur.write_first = 1'b0;
									next_cur.ack_ok      = byte_in == TSR_PTR_TEMPERATURE
										|| byte_in == TSR_PTR_CONTROL;
									if (byte_in == TSR_PTR_TEMPERATURE || byte_in == TSR_PTR_CONTROL) begin
										next_cur.pointer = byte_in;
									end
								end else if (cur.pointer == TSR_PTR_CONTROL) begin
									next_cur.ack_ok = 1'b1;
									if (!cur.write_data_seen) begin
										// Only the first data byte counts
										next_cur.write_data_seen = 1'b1;
										next_cur.fault_clear     = 1'b1;
										next_cur.control         = {byte_in[7] & byte_in[0], byte_in[6:0]};
									end
								end else begin
									next_cur.ack_ok = 1'b0;
								end
							end
							default: begin
								next_cur.ack_ok = cur.ack_ok;
							end
						endcase
					end
				end
			end

			// Data line changes only while the serial clock is low
			if (scl_fall) begin
				case (cur.bus_state)
					TSR_ADDR, TSR_WRITE: begin
						next_cur.sda_oe = (cur.bit_count == TSR_BIT_ACK_SLOT) && cur.ack_ok;
					end
					TSR_READ: begin
						if (cur.bit_count == TSR_BIT_ACK_SLOT) begin
							next_cur.sda_oe = 1'b0;
						end else begin
							next_cur.sda_oe = ~out_byte[~cur.bit_count[2:0]];
						end
					end
					default: begin
						next_cur.sda_oe = 1'b0;
					end
				endcase
			end
		end

		// Reset state: pins idle high, control from stored copy
		if (i_reset) begin
			next_cur                 = '0;
			next_cur.scl_s1          = 1'b1;
			next_cur.scl_s2          = 1'b1;
			next_cur.sda_s1          = 1'b1;
			next_cur.sda_s2          = 1'b1;
			next_cur.scl_prev        = 1'b1;
			next_cur.sda_prev        = 1'b1;
			next_cur.bus_state       = TSR_IDLE;
			next_cur.shift_in        = TSR_SHIFT_RESET;
			next_cur.out_word        = TSR_WORD_RESET;
			next_cur.pointer         = TSR_PTR_RESET;
			next_cur.temperature     = TSR_TEMP_RESET;
			next_cur.control         = i_nv_control & ~(8'h80);
			next_cur.boot_shot       = 1'b1;
		end
	end

	// State register, every clock
	always_ff @(posedge i_clk) begin
		cur <= next_cur;
	end

	// Outputs straight from flip-flops, except o_sda_out tied low
	assign o_sda_out                = 1'b0;
	assign o_sda_oe                 = cur.sda_oe;
	assign o_nv_store               = cur.nv_store;
	assign o_nv_control_data        = cur.nv_data;
	assign o_conv_start             = cur.conv_start;
	assign o_conversion_precision   = cur.control[TSR_CTL_PREC_HI:TSR_CTL_PREC_LO];
	assign o_fault_queue_depth      = cur.control[TSR_CTL_FAULT_HI:TSR_CTL_FAULT_LO];
	assign o_alarm_active_level     = cur.control[TSR_CTL_ALARM_LEVEL];
	assign o_alarm_behaviour_select = cur.control[TSR_CTL_ALARM_BEHAV];
	assign o_power_down_select      = cur.control[TSR_CTL_POWER_DOWN];
	assign o_fault_count_clear      = cur.fault_clear;

endmodule : tsr_temp_sensor
